// [core/scan_tap_pkg.sv]
// Constants, state and instruction types of the boundary-scan port
package scan_tap_pkg;

  localparam int          IR_WIDTH      = 3;
  localparam int          ID_WIDTH      = 32;
  localparam int          BSR_WIDTH     = 16;
  localparam int          PIN_WIDTH     = 12;
  localparam int          RESET_ONES    = 5;
  localparam logic [1:0]  IR_CAPTURE    = 2'h1;
  localparam logic [31:0] ID_CODE_VALUE = 32'h0000_1001; // Arbitrary value
  localparam logic [3:0]  FILLER_ONES   = 4'hF;

  typedef enum logic [2:0] {
    INS_EXTEST  = 3'h0,
    INS_IDCODE  = 3'h1,
    INS_SAMPLEZ = 3'h2,
    INS_RFU0    = 3'h3,
    INS_PRELOAD = 3'h4,
    INS_PRIVATE = 3'h5,
    INS_RFU1    = 3'h6,
    INS_BYPASS  = 3'h7
  } instr_t;

  typedef enum logic [15:0] {
    ST_RESET    = 16'h0001,
    ST_IDLE     = 16'h0002,
    ST_SEL_DR   = 16'h0004,
    ST_CAP_DR   = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR   = 16'h0100,
    ST_SEL_IR   = 16'h0200,
    ST_CAP_IR   = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } tap_state_t;

endpackage

// [core/scan_tap.sv]
// Boundary-scan test access port sampled on the system clock
// Behaviour
// - Test inputs are taken on rising test clock, outputs change on falling.
// - An undriven mode select reads as one.
// - An undriven serial data input reads as one.
// - Serial output is driven only while a register shifts.
// - No test reset pin; five ones on mode select reach reset.
// - The controller resets itself at power-up.
// - With no test clock edges the controller holds its state.
// - Each register shifts in on rising edge, out on falling.
// - One register at a time sits between serial in and out.
// - Instruction register is 3 bits, loaded only while in the path.
// - Identification instruction is loaded at power-up and in reset state.
// - A one-bit bypass register gives one stage of delay.
// - Capture-DR loads pin levels into boundary register, Shift-DR shifts it.
// - Boundary cells tied to no pin capture one in Capture-DR.
// - Boundary register serves high-Z sample, sample/preload and extest.
// - Identification instruction captures a 32-bit constant code and shifts it.
// - Identification code shifts out least significant bit first.
// - Encodings as listed; 011 and 110 act as bypass; 101 private, decoded as bypass here.
// - Capture-IR loads 01 into the two low instruction bits.
// - A new instruction takes effect only in Update-IR.
// - High-Z sample instruction forces memory outputs to high impedance.
module scan_tap
  import scan_tap_pkg::*;
(
  // System
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Test pins; a low enable means the pin is not driven by the tester
  input  wire logic                 testClk,
  input  wire logic                 modeSel,
  input  wire logic                 modeSelDriven,
  input  wire logic                 dataIn,
  input  wire logic                 dataInDriven,
  output logic                      dataOut,
  output logic                      dataOutEn_n,
  // Memory pin levels and output control
  input  wire logic [PIN_WIDTH-1:0] pinLevels,
  output logic                      outputsHighZ,
  output logic                      extestActive
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  logic       tckOld_reg;

  always_ff @(posedge clk) begin
    syncA_reg <= {testClk, modeSel, modeSelDriven, dataIn, dataInDriven};
    syncB_reg <= syncA_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tckOld_reg <= 1'b0;
    end else begin
      tckOld_reg <= syncB_reg[4];
    end
  end

  wire tckRise = syncB_reg[4] & ~tckOld_reg;
  wire tckFall = ~syncB_reg[4] & tckOld_reg;
  wire tms     = syncB_reg[2] ? syncB_reg[3] : 1'b1;
  wire tdi     = syncB_reg[0] ? syncB_reg[1] : 1'b1;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  tap_state_t state_reg;
  tap_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET:    state_next = tms ? ST_RESET : ST_IDLE;
      ST_IDLE:     state_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   state_next = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   state_next = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   state_next = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   state_next = tms ? ST_SEL_DR : ST_IDLE;
      default:     state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_RESET;
    end else if (tckRise) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  instr_t irActive_reg;
  logic [IR_WIDTH-1:0] irShift_reg;

  wire selBsr = (irActive_reg == INS_EXTEST) || (irActive_reg == INS_SAMPLEZ)
             || (irActive_reg == INS_PRELOAD);
  wire selId  = (irActive_reg == INS_IDCODE);
  wire selByp = ~selBsr & ~selId;
  wire inCapDr   = (state_reg == ST_CAP_DR);
  wire inShiftDr = (state_reg == ST_SHIFT_DR);
  wire inShiftIr = (state_reg == ST_SHIFT_IR);

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      irShift_reg  <= INS_IDCODE;
      irActive_reg <= INS_IDCODE;
    end else if (tckRise) begin
      if (state_reg == ST_RESET) begin
        irActive_reg <= INS_IDCODE;
      end else if (state_reg == ST_CAP_IR) begin
        irShift_reg <= {irShift_reg[IR_WIDTH-1:2], IR_CAPTURE};
      end else if (inShiftIr) begin
        irShift_reg <= {tdi, irShift_reg[IR_WIDTH-1:1]};
      end else if (state_reg == ST_UPD_IR) begin
        irActive_reg <= instr_t'(irShift_reg);
      end
    end
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  logic                 bypass_reg;
  logic [ID_WIDTH-1:0]  idShift_reg;
  logic [BSR_WIDTH-1:0] bsr_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      bypass_reg  <= 1'b0;
      idShift_reg <= '0;
      bsr_reg     <= '0;
    end else if (tckRise) begin
      if (inCapDr && selByp) begin
        bypass_reg <= 1'b0;
      end else if (inShiftDr && selByp) begin
        bypass_reg <= tdi;
      end
      if (inCapDr && selId) begin
        idShift_reg <= ID_CODE_VALUE;
      end else if (inShiftDr && selId) begin
        idShift_reg <= {tdi, idShift_reg[ID_WIDTH-1:1]};
      end
      if (inCapDr && selBsr) begin
        bsr_reg <= {FILLER_ONES, pinLevels};
      end else if (inShiftDr && selBsr) begin
        bsr_reg <= {tdi, bsr_reg[BSR_WIDTH-1:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output on falling edge
  // ----------------------------------------------------------------
  wire drBit  = selBsr ? bsr_reg[0] : (selId ? idShift_reg[0] : bypass_reg);
  wire outBit = inShiftIr ? irShift_reg[0] : drBit;
  wire shifting = inShiftIr | inShiftDr;

  always_ff @(posedge clk) begin
    if (rst) begin
      dataOut     <= 1'b0;
      dataOutEn_n <= 1'b1;
    end else if (tckFall) begin
      dataOut     <= outBit;
      dataOutEn_n <= ~shifting;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outputsHighZ <= 1'b0;
      extestActive <= 1'b0;
    end else begin
      outputsHighZ <= (irActive_reg == INS_SAMPLEZ);
      extestActive <= (irActive_reg == INS_EXTEST);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [2:0] onesCnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      onesCnt_reg <= '0;
    end else if (tckRise) begin
      onesCnt_reg <= tms ? ((onesCnt_reg == 3'h7) ? onesCnt_reg : onesCnt_reg + 3'h1) : 3'h0;
    end
  end

  sequence s_fiveOnes;
    onesCnt_reg >= 3'h5;
  endsequence

  property p_resetByOnes;
    @(posedge clk) disable iff (rst) s_fiveOnes |-> state_reg == ST_RESET;
  endproperty
  a_resetByOnes: assert property (p_resetByOnes) else $error("Five ones not in reset");

  property p_noEdgeHold;
    @(posedge clk) disable iff (rst) !tckRise |=> $stable(state_reg);
  endproperty
  a_noEdgeHold: assert property (p_noEdgeHold) else $error("State moved without edge");

  property p_outOnFall;
    @(posedge clk) disable iff (rst) !$past(tckFall) |-> $stable(dataOut);
  endproperty
  a_outOnFall: assert property (p_outOnFall) else $error("Output changed off fall");

  property p_enOnlyShift;
    @(posedge clk) disable iff (rst) $past(tckFall) |-> dataOutEn_n == !$past(shifting);
  endproperty
  a_enOnlyShift: assert property (p_enOnlyShift) else $error("Output enabled off shift");

  property p_idInReset;
    @(posedge clk) disable iff (rst)
      (tckRise && state_reg == ST_RESET) |=> irActive_reg == INS_IDCODE;
  endproperty
  a_idInReset: assert property (p_idInReset) else $error("No idcode in reset");

  property p_capIr;
    @(posedge clk) disable iff (rst)
      (tckRise && state_reg == ST_CAP_IR) |=> irShift_reg[1:0] == IR_CAPTURE;
  endproperty
  a_capIr: assert property (p_capIr) else $error("Capture-IR pattern wrong");

  property p_updOnly;
    @(posedge clk) disable iff (rst)
      (state_reg != ST_UPD_IR && state_reg != ST_RESET) |=> $stable(irActive_reg);
  endproperty
  a_updOnly: assert property (p_updOnly) else $error("Instruction changed early");

  property p_capId;
    @(posedge clk) disable iff (rst)
      (tckRise && inCapDr && selId) |=> idShift_reg == ID_CODE_VALUE;
  endproperty
  a_capId: assert property (p_capId) else $error("Id code not captured");

  property p_filler;
    @(posedge clk) disable iff (rst)
      (tckRise && inCapDr && selBsr) |=> bsr_reg[BSR_WIDTH-1 -: 4] == FILLER_ONES;
  endproperty
  a_filler: assert property (p_filler) else $error("Filler cells not one");

  property p_highZ;
    @(posedge clk) disable iff (rst) (irActive_reg == INS_SAMPLEZ) |=> outputsHighZ;
  endproperty
  a_highZ: assert property (p_highZ) else $error("High-Z not forced");

  property p_outFromPath;
    @(posedge clk) disable iff (rst) $past(tckFall) |-> dataOut == $past(outBit);
  endproperty
  a_outFromPath: assert property (p_outFromPath) else $error("Output not from path");

  property p_irHold;
    @(posedge clk) disable iff (rst)
      !(tckRise && (state_reg == ST_CAP_IR || inShiftIr)) |=> $stable(irShift_reg);
  endproperty
  a_irHold: assert property (p_irHold) else $error("Instruction shifted off path");

  property p_bypassCap;
    @(posedge clk) disable iff (rst) (tckRise && inCapDr && selByp) |=> !bypass_reg;
  endproperty
  a_bypassCap: assert property (p_bypassCap) else $error("Bypass not cleared");

  property p_bsrShift;
    @(posedge clk) disable iff (rst)
      (tckRise && inShiftDr && selBsr) |=> bsr_reg[BSR_WIDTH-1] == $past(tdi);
  endproperty
  a_bsrShift: assert property (p_bsrShift) else $error("Boundary shift wrong");

  property p_idShift;
    @(posedge clk) disable iff (rst)
      (tckRise && inShiftDr && selId) |=> idShift_reg[ID_WIDTH-1] == $past(tdi);
  endproperty
  a_idShift: assert property (p_idShift) else $error("Id shift wrong");

  property p_extest;
    @(posedge clk) disable iff (rst) (irActive_reg == INS_EXTEST) |=> extestActive;
  endproperty
  a_extest: assert property (p_extest) else $error("Extest not flagged");

endmodule

// [testbench/scan_tester.sv]
// Behavioural board tester driving the test pins of the scan port
module scan_tester (
  // System
  input  wire logic clk,
  // Serial output from the port
  input  wire logic dataOut,
  input  wire logic dataOutEn_n,
  // Test pins
  output logic      testClk,
  output logic      modeSel,
  output logic      modeSelDriven,
  output logic      dataIn,
  output logic      dataInDriven
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    testClk       = 1'b0;
    modeSel       = 1'b1;
    modeSelDriven = 1'b1;
    dataIn        = 1'b1;
    dataInDriven  = 1'b1;
  end

  // -----------------------------------------------------------------
  // One test clock period: low 4 clk, high 4 clk, output read after 3 clk high
  // -----------------------------------------------------------------
  task automatic step(input logic tms, input logic tmsDrv, input logic tdi,
                      input logic tdiDrv, output logic tdo, output logic en_n);
    @(posedge clk);
    testClk       <= 1'b0;
    modeSelDriven <= tmsDrv;
    dataInDriven  <= tdiDrv;
    modeSel       <= tmsDrv ? tms : ~modeSel;           // Released pin flips
    dataIn        <= tdiDrv ? tdi : ~dataIn;
    repeat (4) @(posedge clk);
    testClk       <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    tdo  = dataOut;
    en_n = dataOutEn_n;
  endtask
endmodule

// [testbench/sram_boundary_scan_tap_bench.sv]
// Self-checking bench for the boundary-scan port
module sram_boundary_scan_tap_bench
  import scan_tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 testClk, modeSel, modeSelDriven, dataIn, dataInDriven;
  logic                 dataOut, dataOutEn_n, outputsHighZ, extestActive;
  logic [PIN_WIDTH-1:0] pinLevels = 12'h5A3;
  logic                 msDrv = 1'b1;
  logic                 diDrv = 1'b1;
  int                   err_count = 0;
  int                   checks_done = 0;

  always #12.5 clk = ~clk;

  scan_tap u_scan_tap (.clk(clk), .rst(rst), .testClk(testClk), .modeSel(modeSel),
    .modeSelDriven(modeSelDriven), .dataIn(dataIn), .dataInDriven(dataInDriven),
    .dataOut(dataOut), .dataOutEn_n(dataOutEn_n), .pinLevels(pinLevels),
    .outputsHighZ(outputsHighZ), .extestActive(extestActive));

  scan_tester u_scan_tester (.clk(clk), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n),
    .testClk(testClk), .modeSel(modeSel), .modeSelDriven(modeSelDriven),
    .dataIn(dataIn), .dataInDriven(dataInDriven));

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tck(input logic tms, input logic tdi, output logic o, output logic e);
    u_scan_tester.step(tms, msDrv, tdi, diDrv, o, e);
  endtask

  // From idle: scan n bits through IR or DR, back to idle
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
                      output logic [39:0] dout);
    logic o, e;
    dout = '0;
    tck(1'b1, 1'b1, o, e);
    if (ir) tck(1'b1, 1'b1, o, e);
    tck(1'b0, 1'b1, o, e);
    tck(1'b0, 1'b1, o, e);
    for (int i = 0; i < n; i++) begin
      tck(i == n - 1, din[i], o, e);
      dout[i] = o;
      check("enable in shift", e, 40'h0);
    end
    tck(1'b1, 1'b1, o, e);
    check("enable after shift", e, 40'h1);
    tck(1'b0, 1'b1, o, e);
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_power();
    repeat (40) @(posedge clk);
    check("idle enable", dataOutEn_n, 40'h1);
    check("idle high-z", outputsHighZ, 40'h0);
    check("idle extest", extestActive, 40'h0);
  endtask

  task automatic t_idcode();
    logic [39:0] d;
    logic        o, e;
    tck(1'b0, 1'b1, o, e);
    check("enable in idle", e, 40'h1);
    scan(1'b1, 3, 40'h7, d);
    msDrv = 1'b0;
    repeat (5) tck(1'b0, 1'b1, o, e);
    msDrv = 1'b1;
    tck(1'b0, 1'b1, o, e);
    diDrv = 1'b0;
    scan(1'b0, 33, 40'h0, d);
    diDrv = 1'b1;
    check("id code", d, {7'h00, 1'b1, ID_CODE_VALUE});
  endtask

  task automatic t_ircapture();
    logic [39:0] d;
    scan(1'b1, 3, 40'h7, d);
    check("ir capture", d, 40'h5);
    scan(1'b0, 2, 40'h1, d);
    check("bypass delay", d, 40'h2);
  endtask

  task automatic t_bypass_codes();
    logic [39:0] d;
    logic [2:0]  codes [3] = '{3'h3, 3'h5, 3'h6};
    foreach (codes[k]) begin
      scan(1'b1, 3, {37'h0, codes[k]}, d);
      scan(1'b0, 4, 40'hB, d);
      check("bypass code", d, 40'h6);
    end
  endtask

  task automatic t_boundary();
    logic [39:0] d;
    logic [2:0]  codes [3] = '{3'h4, 3'h2, 3'h0};
    foreach (codes[k]) begin
      scan(1'b1, 3, {37'h0, codes[k]}, d);
      repeat (2) @(negedge clk);
      check("high-z", outputsHighZ, 40'(codes[k] == 3'h2));
      check("extest", extestActive, 40'(codes[k] == 3'h0));
      scan(1'b0, BSR_WIDTH, 40'h0, d);
      check("boundary", d, {24'h0, FILLER_ONES, pinLevels});
    end
  endtask

  // -----------------------------------------------------------------
  // Main sequence and hang guard
  // -----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_power();
    t_idcode();
    t_ircapture();
    t_bypass_codes();
    t_boundary();
    results();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
